// ### cam_pkg.sv
// Constants, types and register map of the curve adoption register bank
package cam_pkg;

  // Curve models 705..712, droop model 711 sits at index 6
  localparam int           NUM_MODELS     = 8;
  localparam int           MAX_PTS        = 14;
  localparam logic [15:0]  FIRST_MODEL_ID = 16'h02c1;

  // Register numbers are one-based; the bus carries number minus one
  localparam logic [15:0]  REG_ONE        = 16'h0001;
  localparam logic [15:0]  NUM_SIG        = 16'h9c41;
  localparam logic [15:0]  NUM_CFG_ERR    = 16'ha322;
  localparam logic [15:0]  NUM_MODEL_BASE = 16'ha029;
  localparam logic [15:0]  ADDR_SIG_HI    = NUM_SIG - REG_ONE;
  localparam logic [15:0]  ADDR_SIG_LO    = ADDR_SIG_HI + REG_ONE;
  localparam logic [15:0]  ADDR_CFG_ERR   = NUM_CFG_ERR - REG_ONE;
  localparam logic [15:0]  ADDR_MODEL     = NUM_MODEL_BASE - REG_ONE;
  localparam logic [15:0]  MODEL_SPAN     = 16'h0100;

  // Field offsets inside one model's 32-register window
  localparam logic [4:0]   OFS_ENABLE     = 5'h00;
  localparam logic [4:0]   OFS_ADOPT      = 5'h01;
  localparam logic [4:0]   OFS_OUTCOME    = 5'h02;
  localparam logic [4:0]   OFS_ACT        = 5'h04;
  localparam logic [4:0]   OFS_SCR        = 5'h12;

  localparam logic [15:0]  ADOPT_SCRATCH  = 16'h0002;
  localparam logic [15:0]  EN_ON          = 16'h0001;
  localparam logic [15:0]  NI_U16         = 16'hffff;

  typedef enum logic [15:0] {
    OUT_PENDING  = 16'h0000,
    OUT_DONE     = 16'h0001,
    OUT_REJECTED = 16'h0002
  } cam_outcome_t;

  // Gray path: POR -> IDLE -> CHECK -> BACKUP; the return BACKUP -> IDLE flips both bits
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CHECK  = 2'b01,
    ST_BACKUP = 2'b11,
    ST_POR    = 2'b10
  } cam_adopt_st_t;

  // Backup normally completes between these times
  localparam int           BACKUP_MIN_MS  = 30;
  localparam int           BACKUP_MAX_MS  = 250;
  localparam int           CLK_KHZ        = 200000;
  localparam int           BACKUP_MAX_CYC = BACKUP_MAX_MS * CLK_KHZ;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cam_req_t;

endpackage : cam_pkg

// ### cam_adopt_fsm.sv
// Adoption sequencer for one curve model
`timescale 1ns/100ps
`default_nettype none

module cam_adopt_fsm
  import cam_pkg::*;
#(
  parameter int TIMEOUT_CYC = BACKUP_MAX_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // From the register bank
  input  wire logic        porGo,
  input  wire logic        adoptWr,
  input  wire logic [15:0] adoptVal,
  // Validator
  output logic             chkReq,
  output logic             chkSel,
  input  wire logic        chkDone,
  input  wire logic        chkOk,
  // Nonvolatile backup
  output logic             nvReq,
  input  wire logic        nvDone,
  // Effects on the bank
  output logic             copyStb,
  output logic             porFail,
  output logic             adoptDone,
  output cam_outcome_t     outcome
);

  // The backup counter below is 26 bits wide
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 67108863) begin : gBadTimeout
    $error("cam_adopt_fsm: TIMEOUT_CYC out of range");
  end

  cam_adopt_st_t state_q, state_d;
  cam_outcome_t  outcome_q, outcome_d;
  logic [25:0]   tmo_q;

  wire logic tmoHit   = (tmo_q == 26'(TIMEOUT_CYC - 1));
  wire logic inCheck  = (state_q == ST_CHECK);
  wire logic inBackup = (state_q == ST_BACKUP);

  assign chkReq  = (state_q == ST_POR && porGo) || inCheck;
  assign chkSel  = inCheck;
  assign nvReq   = inBackup;
  assign copyStb = inCheck && chkDone && chkOk;
  assign porFail = (state_q == ST_POR) && porGo && chkDone && !chkOk;
  assign adoptDone = inBackup && nvDone;
  assign outcome = outcome_q;

  always_comb begin
    state_d   = state_q;
    outcome_d = outcome_q;
    case (state_q)
      ST_POR: begin
        if (porGo && chkDone) begin
          state_d = ST_IDLE;
          if (!chkOk) begin
            outcome_d = OUT_REJECTED;
          end
        end
      end
      ST_IDLE: begin
        if (adoptWr) begin
          if (adoptVal == ADOPT_SCRATCH) begin
            state_d   = ST_CHECK;
            outcome_d = OUT_PENDING;
          end else begin
            outcome_d = OUT_REJECTED;
          end
        end
      end
      ST_CHECK: begin
        if (chkDone) begin
          state_d   = chkOk ? ST_BACKUP : ST_IDLE;
          outcome_d = chkOk ? OUT_PENDING : OUT_REJECTED;
        end
      end
      ST_BACKUP: begin
        // A backup that never finishes must not leave the host waiting
        if (nvDone) begin
          state_d   = ST_IDLE;
          outcome_d = OUT_DONE;
        end else if (tmoHit) begin
          state_d   = ST_IDLE;
          outcome_d = OUT_REJECTED;
        end
      end
      default: begin
        state_d   = ST_IDLE;
        outcome_d = OUT_REJECTED;
      end
    endcase
  end

  // Writes outside IDLE fall through untouched
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q   <= ST_POR;
      outcome_q <= OUT_DONE;
    end else begin
      state_q   <= state_d;
      outcome_q <= outcome_d;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tmo_q <= 26'h0000000;
    end else begin
      tmo_q <= inBackup ? tmo_q + 26'h0000001 : 26'h0000000;
    end
  end

endmodule : cam_adopt_fsm

`default_nettype wire

// ### cam_curve_regs.sv
// Curve adoption register bank: point sets, enables, outcome and signature
`timescale 1ns/100ps
`default_nettype none

module cam_curve_regs
  import cam_pkg::*;
#(
  parameter int          NPTS        = 8,
  parameter int          TIMEOUT_CYC = BACKUP_MAX_CYC,
  // Arbitrary value, replace with the assigned protocol signature
  parameter logic [31:0] SIGNATURE   = 32'h1234abcd
) (
  // Clock and reset
  input  wire logic                                   clk_sys,
  input  wire logic                                   reset,
  // Holding register access, address is number minus one
  input  wire logic                                   regValid,
  input  wire cam_req_t                               regReq,
  output logic                                        regAck,
  output logic [15:0]                                 regRdata,
  // Stored active sets presented by nonvolatile storage
  input  wire logic [NUM_MODELS-1:0][NPTS-1:0][15:0]  nvImage,
  // Nonvolatile backup handshake
  output logic [NUM_MODELS-1:0]                       nvReq,
  input  wire logic [NUM_MODELS-1:0]                  nvDone,
  // Function-specific curve validator
  output logic [NUM_MODELS-1:0]                       chkReq,
  output logic [NUM_MODELS-1:0]                       chkSel,
  input  wire logic [NUM_MODELS-1:0]                  chkDone,
  input  wire logic [NUM_MODELS-1:0]                  chkOk,
  // Curve functions
  output logic [NUM_MODELS-1:0][NPTS-1:0][15:0]       activePts,
  output logic [NUM_MODELS-1:0][NPTS-1:0][15:0]       scratchPts,
  output logic [NUM_MODELS-1:0]                       functionEn,
  output logic                                        faultInvCfg
);

  // Bus address splits into model select and field within the window
  localparam int         FLD_W   = 5;
  localparam int         SEL_W   = 3;
  // One bit wider than a field: the scratch set may end on the window edge
  localparam logic [5:0] ACT_END = 6'(OFS_ACT) + 6'(NPTS);
  localparam logic [5:0] SCR_END = 6'(OFS_SCR) + 6'(NPTS);

  // Refuse settings the window, the select or the error word cannot hold
  if (NPTS < 1 || NPTS > MAX_PTS) begin : gBadNpts
    $error("cam_curve_regs: NPTS out of range");
  end
  if (NUM_MODELS > (1 << SEL_W) || NUM_MODELS > $bits(regRdata)) begin : gBadMdl
    $error("cam_curve_regs: NUM_MODELS out of range");
  end
  if ((NUM_MODELS << FLD_W) > int'(MODEL_SPAN)) begin : gBadSpan
    $error("cam_curve_regs: model windows exceed the model span");
  end

  logic [NUM_MODELS-1:0][NPTS-1:0][15:0] actPts_q;
  logic [NUM_MODELS-1:0][NPTS-1:0][15:0] scrPts_q;
  logic [NUM_MODELS-1:0]                 enable_q;
  logic [NUM_MODELS-1:0]                 cfgErr_q;
  logic                                  loaded_q;
  logic                                  fault_q;
  logic                                  ack_q;
  logic [15:0]                           rdata_q;

  logic [NUM_MODELS-1:0]                 copyStb;
  logic [NUM_MODELS-1:0]                 porFail;
  logic [NUM_MODELS-1:0]                 adoptDone;
  cam_outcome_t                          outcome [NUM_MODELS];

  // Address decode
  wire logic [15:0]      relAddr    = regReq.addr - ADDR_MODEL;
  wire logic             inModels   = (regReq.addr >= ADDR_MODEL) &&
                                      (relAddr < MODEL_SPAN);
  wire logic [SEL_W-1:0] mSel       = relAddr[FLD_W+SEL_W-1:FLD_W];
  wire logic [FLD_W-1:0] fld        = relAddr[FLD_W-1:0];
  // Field decode inside the selected window
  wire logic             fldEnable  = (fld == OFS_ENABLE);
  wire logic             fldOutcome = (fld == OFS_OUTCOME);
  wire logic             isAct      = (fld >= OFS_ACT) &&
                                      (6'(fld) < ACT_END);
  wire logic             isScr      = (fld >= OFS_SCR) &&
                                      (6'(fld) < SCR_END);
  wire logic [4:0]       actIdx     = fld - OFS_ACT;
  wire logic [4:0]       scrIdx     = fld - OFS_SCR;
  wire logic             wrEn       = regValid && regReq.we && inModels;
  wire logic             wrEnable   = wrEn && fldEnable;
  wire logic             wrAdopt    = wrEn && (fld == OFS_ADOPT);
  wire logic             wrScr      = wrEn && isScr;

  // Single registers outside the model windows
  wire logic             isSigHi    = (regReq.addr == ADDR_SIG_HI);
  wire logic             isSigLo    = (regReq.addr == ADDR_SIG_LO);
  wire logic             isCfgErr   = (regReq.addr == ADDR_CFG_ERR);

  // Per-field read words of the selected model, and the configuration error word
  wire logic [15:0]      enWord     = 16'(enable_q[mSel]);
  wire logic [15:0]      outWord    = 16'(outcome[mSel]);
  wire logic [15:0]      actWord    = actPts_q[mSel][actIdx[3:0]];
  wire logic [15:0]      scrWord    = scrPts_q[mSel][scrIdx[3:0]];
  wire logic [15:0]      cfgWord    = 16'(cfgErr_q);

  // Read selection; anything unmapped answers the not-implemented value
  wire logic [15:0]      rdModel    =
    fldEnable  ? enWord :
    fldOutcome ? outWord :
    isAct      ? actWord :
    isScr      ? scrWord :
                 NI_U16;
  wire logic [15:0]      rdNext     =
    isSigHi  ? SIGNATURE[31:16] :
    isSigLo  ? SIGNATURE[15:0] :
    isCfgErr ? cfgWord :
    inModels ? rdModel :
               NI_U16;

  // One sequencer per model, droop included, no special case for it
  for (genvar m = 0; m < NUM_MODELS; m++) begin : gModel
    // Bus writes aimed at this model
    wire logic hit   = (mSel == SEL_W'(m));
    wire logic scrWr = wrScr && hit;
    wire logic enWr  = wrEnable && hit;
    cam_adopt_fsm #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
    ) uAdopt (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .porGo     (loaded_q),
      .adoptWr   (wrAdopt && hit),
      .adoptVal  (regReq.wdata),
      .chkReq    (chkReq[m]),
      .chkSel    (chkSel[m]),
      .chkDone   (chkDone[m]),
      .chkOk     (chkOk[m]),
      .nvReq     (nvReq[m]),
      .nvDone    (nvDone[m]),
      .copyStb   (copyStb[m]),
      .porFail   (porFail[m]),
      .adoptDone (adoptDone[m]),
      .outcome   (outcome[m])
    );

    // Active set: only the image at start-up or a validated copy
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        actPts_q[m] <= '0;
      end else if (!loaded_q) begin
        actPts_q[m] <= nvImage[m];
      end else if (copyStb[m]) begin
        actPts_q[m] <= scrPts_q[m];
      end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        scrPts_q[m] <= '0;
      end else if (!loaded_q) begin
        scrPts_q[m] <= nvImage[m];
      end else if (scrWr) begin
        scrPts_q[m][scrIdx[3:0]] <= regReq.wdata;
      end
    end

    // A failed power-on check overrides any host write
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        enable_q[m] <= 1'b0;
      end else if (porFail[m]) begin
        enable_q[m] <= 1'b0;
      end else if (enWr) begin
        enable_q[m] <= (regReq.wdata == EN_ON);
      end
    end

    // Set wins over a clear in the same cycle; a later good adoption clears it
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        cfgErr_q[m] <= 1'b0;
      end else if (porFail[m]) begin
        cfgErr_q[m] <= 1'b1;
      end else if (adoptDone[m]) begin
        cfgErr_q[m] <= 1'b0;
      end
    end
  end

  // Image is taken in the first cycle after reset release
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  // Fault stays raised until the next reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else if (|porFail) begin
      fault_q <= 1'b1;
    end
  end

  // Every access is answered exactly one cycle later, writes included
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= regValid;
    end
  end

  // Read data holds between accesses so a slow host can still pick it up
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (regValid) begin
      rdata_q <= rdNext;
    end
  end

  assign regAck      = ack_q;
  assign regRdata    = rdata_q;
  assign activePts   = actPts_q;
  assign scratchPts  = scrPts_q;
  assign functionEn  = enable_q;
  assign faultInvCfg = fault_q;

endmodule : cam_curve_regs

`default_nettype wire

// ### cam_curve_regs_sva.sv
// Port assertions for the curve adoption register bank
`timescale 1ns/100ps
`default_nettype none
module cam_curve_regs_sva
  import cam_pkg::*;
#(
  parameter int          NPTS        = 8,
  parameter int          TIMEOUT_CYC = 64,
  parameter logic [31:0] SIGNATURE   = 32'h1234abcd
) (
  // Clock and reset
  input wire logic                                  clk_sys,
  input wire logic                                  reset,
  // Register bus
  input wire logic                                  regValid,
  input wire cam_req_t                              regReq,
  input wire logic                                  regAck,
  input wire logic [15:0]                           regRdata,
  // Sequencer handshakes and effects
  input wire logic [NUM_MODELS-1:0][NPTS-1:0][15:0] activePts,
  input wire logic [NUM_MODELS-1:0]                 nvReq,
  input wire logic [NUM_MODELS-1:0]                 chkReq,
  input wire logic [NUM_MODELS-1:0]                 chkSel,
  input wire logic [NUM_MODELS-1:0]                 chkDone,
  input wire logic [NUM_MODELS-1:0]                 chkOk,
  input wire logic [NUM_MODELS-1:0]                 functionEn,
  input wire logic                                  faultInvCfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Slack of a few cycles on top of the backup timeout
  localparam int TO_LIM = TIMEOUT_CYC + 3;
  logic       porSeen_q;
  logic [1:0] up_q;
  wire        idle0   = porSeen_q & ~chkReq[0] & ~nvReq[0];
  wire        passAny = |(chkReq & chkSel & chkDone & chkOk);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      porSeen_q <= 1'b0;
      up_q      <= 2'h0;
    end else begin
      porSeen_q <= porSeen_q | chkDone[0];
      up_q      <= (up_q == 2'h2) ? up_q : up_q + 2'h1;
    end
  end
  sequence s_adopt0;
    regValid && regReq.we && regReq.addr == ADDR_MODEL + 16'h0001 &&
      regReq.wdata == ADOPT_SCRATCH && idle0;
  endsequence
  sequence s_pass0;
    chkReq[0] && chkSel[0] && chkDone[0] && chkOk[0];
  endsequence
  sequence s_porFail1;
    chkReq[1] && !chkSel[1] && chkDone[1] && !chkOk[1];
  endsequence
  a_ack_next: assert property (regValid |=> regAck)
    else $error("access not answered next cycle");
  a_unmapped_ni: assert property (regValid && !regReq.we &&
    regReq.addr == 16'h0100 |=> regRdata == NI_U16)
    else $error("unmapped read not the not-implemented value");
  a_sig_high: assert property (regValid && !regReq.we &&
    regReq.addr == ADDR_SIG_HI |=> regRdata == SIGNATURE[31:16])
    else $error("signature high word wrong");
  a_active_guard: assert property (up_q == 2'h2 &&
    $changed(activePts) |-> $past(passAny))
    else $error("active set changed without a passing check");
  a_adopt_start: assert property (s_adopt0 |=>
    chkReq[0] && chkSel[0])
    else $error("adoption did not start a scratch check");
  a_backup_start: assert property (s_pass0 |=>
    nvReq[0] && !chkReq[0])
    else $error("passing check did not start backup");
  a_backup_bound: assert property ($rose(nvReq[0]) |->
    ##[1:TO_LIM] !nvReq[0])
    else $error("backup request never ended");
  a_fail_idle: assert property (chkReq[0] && chkDone[0] &&
    !chkOk[0] |=> !chkReq[0] && !nvReq[0])
    else $error("failed check still busy or backing up");
  a_por_fail: assert property (s_porFail1 |=>
    !functionEn[1] && faultInvCfg)
    else $error("invalid stored set left enabled or no fault");
  a_fault_hold: assert property (faultInvCfg |=> faultInvCfg)
    else $error("configuration fault dropped before reset");
endmodule : cam_curve_regs_sva
`default_nettype wire

// ### cam_host_model.sv
// Register host model: single-word holding register accesses
`timescale 1ns/100ps
`default_nettype none
module cam_host_model
  import cam_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Register bus
  output var logic         regValid,
  output var cam_req_t     regReq,
  input  wire logic        regAck,
  input  wire logic [15:0] regRdata
);
  initial begin
    regValid = 1'b0;
    regReq   = '0;
  end
  // One-cycle request pulse; idle fields are inverted so a stale word
  // cannot be mistaken for a live request
  task automatic xfer(input logic we, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_sys);
    regValid = 1'b1;
    regReq   = '{we: we, addr: a, wdata: d};
    @(negedge clk_sys);
    regValid = 1'b0;
    regReq   = ~regReq;
    q        = (regAck === 1'b1) ? regRdata : 16'hxxxx;
  endtask : xfer
endmodule : cam_host_model
`default_nettype wire

// ### test_cam_curve_regs.sv
// Self-checking testbench for the curve adoption register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_cam_curve_regs;
  import cam_pkg::*;
  localparam int          NP  = 8;
  localparam int          TO  = 64;
  localparam logic [31:0] SIG = 32'h5a0f3c96; // Arbitrary value
  logic                                clk_sys = 1'b0;
  logic                                reset   = 1'b1;
  logic                                regValid, regAck, faultInvCfg;
  cam_req_t                            regReq;
  logic [15:0]                         regRdata, q;
  logic [NUM_MODELS-1:0][NP-1:0][15:0] nvImage, activePts, scratchPts, expAct;
  logic [NUM_MODELS-1:0]               nvReq, chkReq, chkSel, functionEn;
  logic [NUM_MODELS-1:0]               nvDone = '0, chkDone = '0, chkOk = '0;
  logic [NUM_MODELS-1:0]               actOk = 8'hfd, scrOk = 8'hff;
  logic                                nvGo = 1'b1;
  int                                  error_cnt = 0, cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Validator answers a cycle after each request; storage stalls on !nvGo
  always @(negedge clk_sys) begin
    chkDone <= chkReq & ~chkDone;
    chkOk   <= (chkSel & scrOk) | (~chkSel & actOk);
    nvDone  <= nvReq & ~nvDone & {NUM_MODELS{nvGo}};
  end
  cam_curve_regs #(.NPTS(NP), .TIMEOUT_CYC(TO), .SIGNATURE(SIG)) DUT (
    .clk_sys, .reset, .regValid, .regReq, .regAck, .regRdata, .nvImage,
    .nvReq, .nvDone, .chkReq, .chkSel, .chkDone, .chkOk, .activePts,
    .scratchPts, .functionEn, .faultInvCfg);
  cam_host_model host (.clk_sys, .regValid, .regReq, .regAck, .regRdata);
  function automatic logic [15:0] ma(int m, logic [4:0] f);
    return ADDR_MODEL + 16'(m * 32) + 16'(f);
  endfunction : ma
  function automatic void setExp(int m, logic [15:0] b);
    for (int p = 0; p < NP; p++) expAct[m][p] = b + 16'(p);
  endfunction : setExp
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000, q);
    `CHK(q, e)
  endtask : rd
  task automatic adopt(input int m, input logic [15:0] v,
                       input logic [15:0] b);
    for (int p = 0; p < NP; p++) wr(ma(m, OFS_SCR + 5'(p)), b + 16'(p));
    wr(ma(m, OFS_ADOPT), v);
  endtask : adopt
  task automatic t_power_on();
    `CHK(faultInvCfg, 1'b1)
    `CHK(functionEn, 8'h00)
    `CHK(activePts, nvImage)
    `CHK(scratchPts, nvImage)
    rd(ADDR_CFG_ERR, 16'h0002);
    rd(ma(1, OFS_OUTCOME), OUT_REJECTED);
    rd(ma(0, OFS_SCR + 5'h03), nvImage[0][3]);
    $display("test power_on done");
  endtask : t_power_on
  task automatic t_regs();
    wr(ADDR_SIG_HI, 16'h0000);
    rd(ADDR_SIG_HI, SIG[31:16]);
    rd(ADDR_SIG_LO, SIG[15:0]);
    rd(16'h0100, NI_U16);
    rd(ma(0, OFS_ADOPT), NI_U16);
    wr(ma(0, OFS_ACT), 16'h0bad);
    rd(ma(0, OFS_ACT), nvImage[0][0]);
    wr(ma(0, OFS_ENABLE), EN_ON);
    rd(ma(0, OFS_ENABLE), EN_ON);
    `CHK(functionEn, 8'h01)
    $display("test regs done");
  endtask : t_regs
  task automatic t_refuse();
    adopt(0, 16'h0001, 16'h3000);
    repeat (3) @(negedge clk_sys);
    rd(ma(0, OFS_OUTCOME), OUT_REJECTED);
    scrOk[0] = 1'b0;
    adopt(0, ADOPT_SCRATCH, 16'h3100);
    repeat (3) @(negedge clk_sys);
    rd(ma(0, OFS_OUTCOME), OUT_REJECTED);
    `CHK(activePts, expAct)
    scrOk[0] = 1'b1;
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_busy();
    nvGo = 1'b0;
    adopt(3, ADOPT_SCRATCH, 16'h4000);
    setExp(3, 16'h4000);
    adopt(3, ADOPT_SCRATCH, 16'h4100);
    rd(ma(3, OFS_OUTCOME), OUT_PENDING);
    repeat (TO) @(negedge clk_sys);
    `CHK(nvReq[3], 1'b0)
    rd(ma(3, OFS_OUTCOME), OUT_REJECTED);
    `CHK(activePts, expAct)
    nvGo = 1'b1;
    $display("test busy done");
  endtask : t_busy
  task automatic t_adopt_all();
    for (int m = 0; m < NUM_MODELS; m++) begin
      nvGo = 1'b0;
      adopt(m, ADOPT_SCRATCH, 16'h2000 + 16'(m * 16));
      setExp(m, 16'h2000 + 16'(m * 16));
      rd(ma(m, OFS_OUTCOME), OUT_PENDING);
      `CHK(nvReq[m], 1'b1)
      `CHK(activePts, expAct)
      nvGo = 1'b1;
      repeat (3) @(negedge clk_sys);
      rd(ma(m, OFS_OUTCOME), OUT_DONE);
    end
    rd(ADDR_CFG_ERR, 16'h0000);
    $display("test adopt_all done");
  endtask : t_adopt_all
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    for (int m = 0; m < NUM_MODELS; m++)
      for (int p = 0; p < NP; p++) nvImage[m][p] = 16'h1000 + 16'(m * 16 + p);
    expAct = nvImage;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    // Lands on the edge of the failing power-on check of model 1
    wr(ma(1, OFS_ENABLE), EN_ON);
    repeat (8) @(negedge clk_sys);
    t_power_on();
    t_regs();
    t_refuse();
    t_busy();
    t_adopt_all();
    conclude();
  end
  // The sequence needs about four hundred cycles; allow fifty times that
  initial begin
    #(20000 * 5);
    error_cnt++;
    conclude();
  end
endmodule : test_cam_curve_regs
bind cam_curve_regs cam_curve_regs_sva #(.NPTS(NPTS),
  .TIMEOUT_CYC(TIMEOUT_CYC), .SIGNATURE(SIGNATURE)) u_sva (.clk_sys, .reset,
  .regValid, .regReq, .regAck, .regRdata, .activePts, .nvReq, .chkReq,
  .chkSel, .chkDone, .chkOk, .functionEn, .faultInvCfg);
`default_nettype wire
